//--- core/sar_port_six_control.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - six-bit successive approximation result on one of four channels
// - fast crystal clock: conversion lasts 242 us from start to result
// - slow crystal clock: conversion lasts seven instruction cycles, 280 us
// - each shared pin has its own writable analog input selection
// - port-input pins get individually enabled pull-up or pull-down
// - each shared pin routes to port, LCD segment, analog or CD signal
module sar_port_six_control
	import sar_port_pkg::*;
#(
	parameter int CONV_HI = CONV_HI_CYCLES
)
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// cpu clock source and instruction strobe
	input wire logic lowClkMode,
	input wire logic instrTick,
	// analog front end
	input wire logic compHigh,
	output logic [RES_W-1:0] dacCode,
	output logic [1:0] analogChannel,
	output logic [CH_N-1:0] analogSwEn,
	// shared pins
	input wire logic [CH_N-1:0] padIn,
	output logic [CH_N-1:0] padOut,
	output logic [CH_N-1:0] padOe,
	output logic [CH_N-1:0] pullUpEn,
	output logic [CH_N-1:0] pullDnEn,
	// lcd segment drive
	input wire logic [CH_N-1:0] lcdSeg,
	// cd processor signals
	input wire logic [CH_N-1:0] cdSigOut,
	input wire logic [CH_N-1:0] cdSigOe,
	output logic [CH_N-1:0] cdSigIn
);

	localparam logic [CNT_W-1:0] HI_TOTAL = CNT_W'(CONV_HI);
	localparam logic [CNT_W-1:0] HI_STEP = CNT_W'(CONV_HI / SLOT_COUNT);
	localparam logic [2:0] LO_LAST = 3'(LO_INSTR_CYCLES);

	conv_state_e state;
	logic [7:0] pinFunc;
	logic [7:0] pullCfg;
	logic [3:0] portOut;
	logic [3:0] portDir;
	logic [RES_W-1:0] result;
	logic done;
	logic [CNT_W-1:0] totalCnt;
	logic [CNT_W-1:0] stepCnt;
	logic [2:0] slot;
	logic modeLow;
	logic compMeta;
	logic compSync;
	logic [CH_N-1:0] padMeta;
	logic [CH_N-1:0] padSync;
	logic startCmd;
	logic doneClr;
	logic decide;
	logic finishConv;
	logic busy;
	logic sarFinished;
	logic [RES_W-1:0] trial;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			compMeta <= 1'b0;
			compSync <= 1'b0;
			padMeta <= '0;
			padSync <= '0;
		end else if (ce) begin
			compMeta <= compHigh;
			compSync <= compMeta;
			padMeta <= padIn;
			padSync <= padMeta;
		end
	end

	assign cdSigIn = padSync;

	////////////////////////////////////////////////////////////////////
	// command decode
	assign busy = (state == ST_CONV);
	assign startCmd = ce && regWr && regAddr == REG_CTRL &&
		regWdata[CTRL_START_BIT] && !busy;
	assign doneClr = (regWr && regAddr == REG_STATUS &&
		regWdata[STAT_DONE_BIT]) || startCmd;

	////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			pinFunc <= RST_PINFUNC;
			pullCfg <= RST_PULL;
			portOut <= RST_PORTOUT;
			portDir <= RST_PORTDIR;
		end else if (ce && regWr) begin
			unique case (regAddr)
				REG_PINFUNC: pinFunc <= regWdata;
				REG_PULL: pullCfg <= regWdata;
				REG_PORTOUT: portOut <= regWdata[3:0];
				REG_PORTDIR: portDir <= regWdata[3:0];
				default: ;
			endcase
		end
	end

	// channel only changes with an accepted start, so a busy
	// conversion never sees its input switched under it
	always_ff @(posedge clk) begin
		if (rst) begin
			analogChannel <= RST_CHANNEL;
		end else if (startCmd) begin
			analogChannel <= regWdata[CTRL_CH_LSB+:2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// conversion sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else if (ce) begin
			unique case (state)
				ST_IDLE: if (startCmd) begin
					state <= ST_CONV;
				end
				ST_CONV: if (finishConv) begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// clock source is latched at start; a mid-conversion switch is
	// ignored rather than mixing two time bases
	always_ff @(posedge clk) begin
		if (rst) begin
			modeLow <= 1'b0;
		end else if (startCmd) begin
			modeLow <= lowClkMode;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			totalCnt <= '0;
			stepCnt <= '0;
			slot <= '0;
		end else if (ce) begin
			if (startCmd) begin
				totalCnt <= '0;
				stepCnt <= '0;
				slot <= '0;
			end else if (busy && !modeLow) begin
				totalCnt <= totalCnt + 1'b1;
				if (stepCnt == HI_STEP - 1'b1) begin
					stepCnt <= '0;
					slot <= slot + 1'b1;
				end else begin
					stepCnt <= stepCnt + 1'b1;
				end
			end else if (busy && instrTick) begin
				slot <= slot + 1'b1;
			end
		end
	end

	always_comb begin
		decide = 1'b0;
		finishConv = 1'b0;
		if (busy && !modeLow) begin
			decide = (stepCnt == HI_STEP - 1'b1) && (slot < 3'(RES_W));
			finishConv = (totalCnt == HI_TOTAL - 1'b1);
		end else if (busy && instrTick) begin
			decide = (slot < 3'(RES_W));
			finishConv = (slot == LO_LAST - 1'b1);
		end
	end

	sar_step_engine sarCore (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.load(startCmd),
		.decide(decide),
		.compHigh(compSync),
		.trial(trial),
		.finished(sarFinished)
	);

	assign dacCode = trial;

	////////////////////////////////////////////////////////////////////
	// result and done flag; a finishing conversion wins over a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			result <= '0;
		end else if (ce && finishConv) begin
			result <= trial;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done <= 1'b0;
		end else if (ce) begin
			if (finishConv) begin
				done <= 1'b1;
			end else if (doneClr) begin
				done <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdata <= '0;
		end else if (ce && regRd) begin
			unique case (regAddr)
				REG_CTRL: regRdata <= {4'h0, busy, analogChannel, 1'b0};
				REG_STATUS: regRdata <= {6'h00, busy, done};
				REG_RESULT: regRdata <= {2'h0, result};
				REG_PINFUNC: regRdata <= pinFunc;
				REG_PULL: regRdata <= pullCfg;
				REG_PORTOUT: regRdata <= {4'h0, portOut};
				REG_PORTDIR: regRdata <= {4'h0, portDir};
				REG_PORTIN: regRdata <= {4'h0, padSync};
				default: regRdata <= '0;
			endcase
		end else if (ce) begin
			regRdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin routing, one slice per shared pin
	for (genvar i = 0; i < CH_N; i++) begin : g_pin
		logic [1:0] fn;
		logic portIn;
		assign fn = pinFunc[2*i+:2];
		assign portIn = (fn == FN_PORT) && !portDir[i];
		always_comb begin
			unique case (fn)
				FN_PORT: begin
					padOut[i] = portOut[i];
					padOe[i] = portDir[i];
				end
				FN_LCD: begin
					padOut[i] = lcdSeg[i];
					padOe[i] = 1'b1;
				end
				FN_ANALOG: begin
					padOut[i] = 1'b0;
					padOe[i] = 1'b0;
				end
				FN_CD: begin
					padOut[i] = cdSigOut[i];
					padOe[i] = cdSigOe[i];
				end
			endcase
		end
		assign analogSwEn[i] = (fn == FN_ANALOG);
		assign pullUpEn[i] = portIn && pullCfg[i] &&
			pullCfg[PULL_UP_LSB+i];
		assign pullDnEn[i] = portIn && pullCfg[i] &&
			!pullCfg[PULL_UP_LSB+i];
	end

	////////////////////////////////////////////////////////////////////
	// checks
	sequence startSeq;
		startCmd;
	endsequence

	sequence firstTrialSeq;
		busy && dacCode == SAR_MSB;
	endsequence

	sar_start_a: assert property (@(posedge clk) disable iff (rst)
		startSeq |=> firstTrialSeq)
		else $error("first trial code not at midscale");

	start_busy_a: assert property (@(posedge clk) disable iff (rst)
		startSeq |=> busy && !done)
		else $error("start did not begin a conversion");

	hi_time_a: assert property (@(posedge clk) disable iff (rst)
		ce && busy && !modeLow && totalCnt == HI_TOTAL - 1'b1
		|=> !busy && done && sarFinished)
		else $error("fast mode conversion did not end on time");

	hi_early_a: assert property (@(posedge clk) disable iff (rst)
		busy && !modeLow && totalCnt < HI_TOTAL - 1'b1 |-> !finishConv)
		else $error("fast mode conversion ended early");

	lo_time_a: assert property (@(posedge clk) disable iff (rst)
		ce && busy && modeLow && instrTick && slot == LO_LAST - 1'b1
		|=> !busy && done && sarFinished)
		else $error("slow mode conversion not seven cycles");

	result_hold_a: assert property (@(posedge clk) disable iff (rst)
		!$past(finishConv && ce) |-> $stable(result))
		else $error("result changed without a finished conversion");

	ana_pin_a: assert property (@(posedge clk) disable iff (rst)
		analogSwEn != '0 |-> (padOe & analogSwEn) == '0)
		else $error("analog pin is being driven");

	pull_gate_a: assert property (@(posedge clk) disable iff (rst)
		(pullUpEn | pullDnEn) != '0 |->
		((pullUpEn | pullDnEn) & (padOe | analogSwEn)) == '0 &&
		(pullUpEn & pullDnEn) == '0)
		else $error("pull active on a pin that is not a port input");

	lcd_route_a: assert property (@(posedge clk) disable iff (rst)
		pinFunc[1:0] == FN_LCD |-> padOe[0] && padOut[0] == lcdSeg[0])
		else $error("lcd segment not routed to pin zero");

endmodule
`default_nettype wire

//--- core/sar_port_pkg.sv
package sar_port_pkg;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_NS = 10;
	localparam int CONV_HI_US = 242;
	localparam int CONV_HI_CYCLES = (CONV_HI_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CONV_LO_US = 280;
	localparam int LO_INSTR_CYCLES = 7;
	localparam int SLOT_COUNT = 7;
	localparam int CNT_W = 16;

	////////////////////////////////////////////////////////////////////
	// widths
	localparam int RES_W = 6;
	localparam int CH_N = 4;
	localparam logic [RES_W-1:0] SAR_MSB = 6'h20;

	////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_RESULT = 4'h2;
	localparam logic [3:0] REG_PINFUNC = 4'h3;
	localparam logic [3:0] REG_PULL = 4'h4;
	localparam logic [3:0] REG_PORTOUT = 4'h5;
	localparam logic [3:0] REG_PORTDIR = 4'h6;
	localparam logic [3:0] REG_PORTIN = 4'h7;

	////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CH_LSB = 1;
	localparam int CTRL_BUSY_BIT = 3;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int PULL_UP_LSB = 4;

	////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_PINFUNC = 8'h00;
	localparam logic [7:0] RST_PULL = 8'h00;
	localparam logic [3:0] RST_PORTOUT = 4'h0;
	localparam logic [3:0] RST_PORTDIR = 4'h0;
	localparam logic [1:0] RST_CHANNEL = 2'h0;

	////////////////////////////////////////////////////////////////////
	// pin functions, two bits per shared pin
	localparam logic [1:0] FN_PORT = 2'h0;
	localparam logic [1:0] FN_LCD = 2'h1;
	localparam logic [1:0] FN_ANALOG = 2'h2;
	localparam logic [1:0] FN_CD = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} conv_state_e;

endpackage

//--- core/sar_step_engine.sv
`timescale 1ns/100ps
`default_nettype none
module sar_step_engine
	import sar_port_pkg::*;
(
	// clock, reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// sequencing
	input wire logic load,
	input wire logic decide,
	input wire logic compHigh,
	// trial code, final once all bits decided
	output logic [RES_W-1:0] trial,
	output logic finished
);

	logic [RES_W-1:0] mask;

	////////////////////////////////////////////////////////////////////
	// keep the bit under test when the input is above the trial level
	always_ff @(posedge clk) begin
		if (rst) begin
			trial <= '0;
			mask <= '0;
		end else if (ce) begin
			if (load) begin
				trial <= SAR_MSB;
				mask <= SAR_MSB;
			end else if (decide && mask != '0) begin
				trial <= (compHigh ? trial : (trial & ~mask)) | (mask >> 1);
				mask <= mask >> 1;
			end
		end
	end

	assign finished = (mask == '0);

endmodule
`default_nettype wire

//--- verif/analog_source_model.sv
`timescale 1ns/100ps
`default_nettype none
module analog_source_model
	import sar_port_pkg::*;
(
	// clock
	input wire logic clk,
	// converter side
	input wire logic [1:0] analogChannel,
	input wire logic [RES_W-1:0] dacCode,
	input wire logic [CH_N-1:0][RES_W-1:0] level,
	output logic compHigh,
	// shared pins
	input wire logic [CH_N-1:0] padOut,
	input wire logic [CH_N-1:0] padOe,
	input wire logic [CH_N-1:0] pullUpEn,
	input wire logic [CH_N-1:0] pullDnEn,
	output logic [CH_N-1:0] padIn
);
	logic [CH_N-1:0] floatPat = 4'h5;
	////////////////////////////////////////////////////////////////////
	// comparator: selected source against the trial code
	assign compHigh = level[analogChannel] >= dacCode;
	////////////////////////////////////////////////////////////////////
	// a floating pin wanders, so a stale level never passes as valid
	always @(posedge clk) begin
		floatPat <= ~floatPat;
	end
	assign padIn = (padOe & padOut) | (~padOe & pullUpEn)
		| (~padOe & ~pullUpEn & ~pullDnEn & floatPat);
endmodule
`default_nettype wire

//--- verif/sar_port_six_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module sar_port_six_control_test;
	import sar_port_pkg::*;
	// short conversion keeps the run brief
	localparam int CONV = 70;
	logic clk = 0, rst = 1, ce = 1, regWr = 0, regRd = 0;
	logic lowClkMode = 0, instrTick = 0, compHigh;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, regRdata, d;
	logic [RES_W-1:0] dacCode;
	logic [1:0] analogChannel;
	logic [CH_N-1:0] analogSwEn, padIn, padOut, padOe, pullUpEn, pullDnEn;
	logic [CH_N-1:0] cdSigIn, lcdSeg = 4'h0, cdSigOut = 4'h0, cdSigOe = 4'h0;
	logic [CH_N-1:0][RES_W-1:0] level = '0;
	int errTotal = 0, samplesChecked = 0, n;

	sar_port_six_control #(.CONV_HI(CONV)) i_dut (.clk(clk), .rst(rst),
		.ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .lowClkMode(lowClkMode),
		.instrTick(instrTick), .compHigh(compHigh), .dacCode(dacCode),
		.analogChannel(analogChannel), .analogSwEn(analogSwEn),
		.padIn(padIn), .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
		.pullDnEn(pullDnEn), .lcdSeg(lcdSeg), .cdSigOut(cdSigOut),
		.cdSigOe(cdSigOe), .cdSigIn(cdSigIn));
	analog_source_model i_src (.clk(clk), .analogChannel(analogChannel),
		.dacCode(dacCode), .level(level), .compHigh(compHigh),
		.padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
		.pullDnEn(pullDnEn), .padIn(padIn));

	initial begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// successive approximation worked out bit by bit from the source level
	function automatic logic [7:0] expectSar(input logic [RES_W-1:0] lvl);
		logic [RES_W-1:0] code;
		code = '0;
		for (int b = RES_W - 1; b >= 0; b--) begin
			if (lvl >= (code | (RES_W'(1) << b))) begin
				code = code | (RES_W'(1) << b);
			end
		end
		return 8'(code);
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		// step off the edge so callers see the written state settled
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	// strobe held high so the status of every cycle is seen
	task automatic poll(output int k);
		@(posedge clk);
		regAddr <= REG_STATUS;
		regRd <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while (regRdata[STAT_DONE_BIT] !== 1'b1 && k < 400);
		@(posedge clk);
		regRd <= 1'b0;
	endtask
	task automatic results();
		$display("mismatches %0d checks %0d", errTotal, samplesChecked);
		if (errTotal == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge clk);
		errTotal++;
		results();
	end

	initial begin
		logic [7:0] pf, pl;
		logic [3:0] po, pd, eo, eOe, eu, ed, ea, m;
		void'($urandom(32'hFCAD0E9C));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk(8'(padOe | pullUpEn | pullDnEn | analogSwEn), 8'h00);
		wr(4'hC, 8'hFF);
		for (int a = 0; a < 16; a++) begin
			if (a != 7) begin
				rd(4'(a), d);
				chk(d, 8'h00);
			end
		end
		wr(REG_PINFUNC, 8'hAA);
		chk(8'(analogSwEn), 8'h0F);
		for (int c = 0; c < CH_N; c++) begin
			level[c] <= (c == 0) ? 6'h00 : (c == 3) ? 6'h3F : 6'($urandom);
			wr(REG_CTRL, 8'(c * 2 + 1));
			wr(REG_CTRL, 8'(((c + 1) % 4) * 2 + 1));
			poll(n);
			chk(8'(n), 8'(CONV - 2));
			chk(8'(analogChannel), 8'(c));
			rd(REG_RESULT, d);
			chk(d, expectSar(level[c]));
			rd(REG_CTRL, d);
			chk(d, 8'(c * 2));
			wr(REG_STATUS, 8'h01);
			rd(REG_STATUS, d);
			chk(d, 8'h00);
			rd(REG_RESULT, d);
			chk(d, expectSar(level[c]));
		end
		// slow time base: the clock count alone must not finish it
		lowClkMode <= 1'b1;
		level[1] <= 6'($urandom);
		wr(REG_CTRL, 8'h03);
		repeat (CONV + 10) @(posedge clk);
		for (int t = 0; t < 7; t++) begin
			rd(REG_STATUS, d);
			chk(d, 8'h02);
			@(posedge clk);
			instrTick <= 1'b1;
			@(posedge clk);
			instrTick <= 1'b0;
		end
		rd(REG_STATUS, d);
		chk(d, 8'h01);
		rd(REG_RESULT, d);
		chk(d, expectSar(level[1]));
		// frozen enable: twenty idle edges must stretch the conversion
		lowClkMode <= 1'b0;
		level[2] <= 6'($urandom);
		wr(REG_CTRL, 8'h05);
		@(posedge clk);
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		ce <= 1'b1;
		poll(n);
		chk(8'(n), 8'(CONV - 1));
		rd(REG_RESULT, d);
		chk(d, expectSar(level[2]));
		for (int it = 0; it < 8; it++) begin
			pf = 8'($urandom);
			pl = 8'($urandom);
			po = 4'($urandom);
			pd = 4'($urandom);
			lcdSeg <= 4'($urandom);
			cdSigOut <= 4'($urandom);
			cdSigOe <= 4'($urandom);
			wr(REG_PINFUNC, pf);
			wr(REG_PULL, pl);
			wr(REG_PORTOUT, 8'(po));
			wr(REG_PORTDIR, 8'(pd));
			for (int i = 0; i < CH_N; i++) begin
				eOe[i] = (pf[2*i +: 2] == FN_PORT) ? pd[i]
					: (pf[2*i +: 2] == FN_LCD) ? 1'b1
					: (pf[2*i +: 2] == FN_CD) ? cdSigOe[i] : 1'b0;
				eo[i] = (pf[2*i +: 2] == FN_PORT) ? po[i]
					: (pf[2*i +: 2] == FN_LCD) ? lcdSeg[i]
					: (pf[2*i +: 2] == FN_CD) ? cdSigOut[i] : 1'b0;
				ea[i] = pf[2*i +: 2] == FN_ANALOG;
				m[i] = pl[i] & ~pd[i] & (pf[2*i +: 2] == FN_PORT);
				eu[i] = m[i] & pl[PULL_UP_LSB + i];
				ed[i] = m[i] & ~pl[PULL_UP_LSB + i];
			end
			chk(8'(padOe), 8'(eOe));
			chk(8'(padOut & eOe), 8'(eo & eOe));
			chk(8'(analogSwEn), 8'(ea));
			chk(8'(pullUpEn), 8'(eu));
			chk(8'(pullDnEn), 8'(ed));
			rd(REG_PULL, d);
			chk(d, pl);
			rd(REG_PORTDIR, d);
			chk(d, 8'(pd));
			repeat (3) @(posedge clk);
			m = eOe | eu | ed;
			rd(REG_PORTIN, d);
			chk(8'(d[3:0] & m), 8'(((eOe & eo) | eu) & m));
			chk(8'(cdSigIn & m), 8'(((eOe & eo) | eu) & m));
		end
		results();
	end
endmodule
`default_nettype wire
